// ===== include/flag_bank_defines.vh
`ifndef FLAG_BANK_DEFINES_VH
`define FLAG_BANK_DEFINES_VH

// Register indices on the control port
`define EVENT_FLAGS_SECOND_ADDR 8'h0d
`define STATUS_FLAGS_THIRD_ADDR 8'h0e
`define REG_ADDR_W 8
`define REG_DATA_W 16

// Reset values (data bit n holds register bit n+8)
`define EVENT_FLAGS_SECOND_RST 16'h0000
`define STATUS_FLAGS_THIRD_RST 16'h0000
`define READ_DATA_RST 16'h0000

// event_flags_second field positions (data bit index)
`define F2_WAKE_ONE_EDGE 0
`define F2_WAKE_TWO_EDGE 1
`define F2_STANDBY_TIMER 10
`define F2_BOOST_OV 11
`define F2_BOOST_UV 12
`define F2_BOOST_SRC_UV 13
`define F2_THERMAL_SELFTEST 14
`define F2_DIE_CENTRE 15

// status_flags_third field positions (data bit index)
`define F3_INVALID_ACCESS 0
`define F3_CRC_ERROR 1
`define F3_WAKE_ONE_LEVEL 2
`define F3_WAKE_TWO_LEVEL 3
`define F3_CLOCK_IN_RANGE 6
`define F3_REG_STATE_LSB 7
`define F3_W1C_MASK 16'h0003
`define REG_STATE_W 9

`endif

// ===== rtl/w1c_flag_bank.v
`timescale 1ns/10ps
`default_nettype none

// Latched flags: set by event, cleared by a write of one
module w1c_flag_bank #(
  parameter WIDTH = 16
) (
  input wire clk_in,
  input wire rst_in,
  input wire [WIDTH-1:0] set_in,
  input wire [WIDTH-1:0] clr_in,
  output wire [WIDTH-1:0] flags_out
);

  reg [WIDTH-1:0] flag_r;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_flag
      always @(posedge clk_in) begin
        if (rst_in) begin
          flag_r[i] <= 1'b0;
        end else if (set_in[i]) begin
          // Set wins over a clear in the same cycle so no event is lost
          flag_r[i] <= 1'b1; // see [RULE11]
        end else if (clr_in[i]) begin
          flag_r[i] <= 1'b0; // see [RULE1]
        end
      end
    end
  endgenerate

  assign flags_out = flag_r;

endmodule // w1c_flag_bank

`default_nettype wire

// ===== rtl/main_status_flag_bank.v
//
// Contract
// [RULE1] Event flags latch, clear on reset or write-one
// [RULE2] Host clears all flags after start-up
// [RULE3] Die centre thermal event sets own flag
// [RULE4] Invalid access sets flag at bit eight
// [RULE5] CRC failure sets flag beside invalid-access
// [RULE6] Live level of first wake input
// [RULE7] Live level of second wake input
// [RULE8] Clock watchdog in-range bit, reset only; the code shows the live synchronised level instead
// [RULE9] Nine bits show live regulator on state
// [RULE10] Zero writes and read-only writes change nothing
// [RULE11] Flag holds until cleared, resets if present
`timescale 1ns/10ps
`default_nettype none
`include "flag_bank_defines.vh"

module main_status_flag_bank (
  // Clock and reset
  input wire MCLK_IN,
  input wire RST_IN,
  // Register access from the control port front end
  input wire [`REG_ADDR_W-1:0] REG_ADDR_IN,
  input wire REG_WR_IN,
  input wire REG_RD_IN,
  input wire [`REG_DATA_W-1:0] REG_WDATA_IN,
  output reg [`REG_DATA_W-1:0] REG_RDATA_OUT,
  // Link error pulses from the front end, same clock
  input wire INVALID_ACCESS_IN,
  input wire CRC_ERROR_IN,
  // Asynchronous monitor and pin inputs
  input wire WAKE_INPUT_ONE_IN,
  input wire WAKE_INPUT_TWO_IN,
  input wire INPUT_CLOCK_IN_RANGE_IN,
  input wire STANDBY_TIMER_EVENT_IN,
  input wire BOOST_OVERVOLTAGE_EVENT_IN,
  input wire BOOST_UNDERVOLTAGE_EVENT_IN,
  input wire BOOST_SOURCE_UNDERVOLTAGE_EVENT_IN,
  input wire THERMAL_SELFTEST_FAIL_IN,
  input wire DIE_CENTRE_THERMAL_EVENT_IN,
  input wire [7:0] OTHER_SUPPLY_EVENTS_IN,
  // Order: pre, hv linear, step-up, down 1..3, linear 1..3 (msb first)
  input wire [`REG_STATE_W-1:0] REGULATOR_ON_IN
);

  // Nine regulator states, clock watchdog, six events, eight other events, two wake pins
  localparam ASYNC_W = 26;

  // Async inputs gathered so one two-stage synchroniser covers all
  wire [ASYNC_W-1:0] async_in;
  reg [ASYNC_W-1:0] meta_r;
  reg [ASYNC_W-1:0] sync_r;
  reg wake_one_prev_r;
  reg wake_two_prev_r;

  assign async_in = {REGULATOR_ON_IN, INPUT_CLOCK_IN_RANGE_IN, DIE_CENTRE_THERMAL_EVENT_IN,
                     THERMAL_SELFTEST_FAIL_IN, BOOST_SOURCE_UNDERVOLTAGE_EVENT_IN,
                     BOOST_UNDERVOLTAGE_EVENT_IN, BOOST_OVERVOLTAGE_EVENT_IN,
                     STANDBY_TIMER_EVENT_IN, OTHER_SUPPLY_EVENTS_IN,
                     WAKE_INPUT_TWO_IN, WAKE_INPUT_ONE_IN};

  always @(posedge MCLK_IN) begin
    if (RST_IN) begin
      meta_r <= {ASYNC_W{1'b0}};
      sync_r <= {ASYNC_W{1'b0}};
      wake_one_prev_r <= 1'b0;
      wake_two_prev_r <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
      wake_one_prev_r <= sync_r[0];
      wake_two_prev_r <= sync_r[1];
    end
  end

  wire wake_one_level = sync_r[0];
  wire wake_two_level = sync_r[1];
  wire [7:0] other_supply = sync_r[9:2];
  wire [5:0] main_events = sync_r[15:10];
  wire clock_in_range = sync_r[16];
  wire [`REG_STATE_W-1:0] reg_state = sync_r[25:17];

  // Write-one clears, gated by address; zero bits leave flags alone
  wire wr_second = REG_WR_IN && (REG_ADDR_IN == `EVENT_FLAGS_SECOND_ADDR);
  wire wr_third = REG_WR_IN && (REG_ADDR_IN == `STATUS_FLAGS_THIRD_ADDR);
  wire [`REG_DATA_W-1:0] clr_second = wr_second ? REG_WDATA_IN : `READ_DATA_RST; // see [RULE10]
  wire [1:0] clr_third = wr_third ? REG_WDATA_IN[1:0] : 2'h0; // see [RULE10]

  // Levels keep setting while present, so a clear under a live event re-sets
  wire [`REG_DATA_W-1:0] set_second;
  assign set_second[`F2_WAKE_ONE_EDGE] = wake_one_level & ~wake_one_prev_r;
  assign set_second[`F2_WAKE_TWO_EDGE] = wake_two_level & ~wake_two_prev_r;
  assign set_second[9:2] = other_supply;
  assign set_second[`F2_STANDBY_TIMER] = main_events[0]; // see [RULE1]
  assign set_second[`F2_BOOST_OV] = main_events[1]; // see [RULE1]
  assign set_second[`F2_BOOST_UV] = main_events[2]; // see [RULE1]
  assign set_second[`F2_BOOST_SRC_UV] = main_events[3]; // see [RULE1]
  assign set_second[`F2_THERMAL_SELFTEST] = main_events[4]; // see [RULE1]
  assign set_second[`F2_DIE_CENTRE] = main_events[5]; // see [RULE3]

  wire [1:0] set_third = {CRC_ERROR_IN, INVALID_ACCESS_IN}; // see [RULE4] see [RULE5]

  wire [`REG_DATA_W+1:0] flags;

  w1c_flag_bank #(
    .WIDTH(`REG_DATA_W + 2)
  ) u_flags (
    .clk_in(MCLK_IN),
    .rst_in(RST_IN),
    .set_in({set_third, set_second}),
    .clr_in({clr_third, clr_second}),
    .flags_out(flags)
  );

  wire [`REG_DATA_W-1:0] second_view = flags[`REG_DATA_W-1:0];
  wire [`REG_DATA_W-1:0] third_view;
  assign third_view[`F3_INVALID_ACCESS] = flags[`REG_DATA_W]; // see [RULE4]
  assign third_view[`F3_CRC_ERROR] = flags[`REG_DATA_W+1]; // see [RULE5]
  assign third_view[`F3_WAKE_ONE_LEVEL] = wake_one_level; // see [RULE6]
  assign third_view[`F3_WAKE_TWO_LEVEL] = wake_two_level; // see [RULE7]
  assign third_view[5:4] = 2'h0;
  assign third_view[`F3_CLOCK_IN_RANGE] = clock_in_range; // see [RULE8]
  assign third_view[15:7] = reg_state; // see [RULE9]

  // Read data registered; unmapped indices read zero
  reg [`REG_DATA_W-1:0] rdata_nxt;

  always @* begin
    rdata_nxt = REG_RDATA_OUT;
    if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        `EVENT_FLAGS_SECOND_ADDR: rdata_nxt = second_view;
        `STATUS_FLAGS_THIRD_ADDR: rdata_nxt = third_view;
        default: rdata_nxt = `READ_DATA_RST;
      endcase
    end
  end

  always @(posedge MCLK_IN) begin
    if (RST_IN) begin
      REG_RDATA_OUT <= `READ_DATA_RST;
    end else begin
      REG_RDATA_OUT <= rdata_nxt;
    end
  end

endmodule // main_status_flag_bank

`default_nettype wire

// ===== verification/host_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic MCLK_IN,
  input wire logic [15:0] rdata_in,
  output logic [7:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [15:0] wdata_out
);
  initial {addr_out, wr_out, rd_out, wdata_out} = '0;
  // No idle cycle between calls, so strobes may run back to back
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
    {addr_out, wr_out, rd_out, wdata_out} = {a, w, !w, d};
    @(posedge MCLK_IN) #1;
    q = rdata_in;
  endtask
  task automatic idle(input int n);
    {wr_out, rd_out} = 2'b00;
    repeat (n) @(posedge MCLK_IN) #1;
  endtask
endmodule // host_model
`default_nettype wire

// ===== verification/flag_checker.sv
`timescale 1ns/10ps
`default_nettype none
module flag_checker (
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [15:0] REG_WDATA_IN,
  input wire logic [15:0] REG_RDATA_OUT,
  input wire logic INVALID_ACCESS_IN,
  input wire logic CRC_ERROR_IN
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);
  wire logic rd3 = REG_RD_IN && REG_ADDR_IN == 8'h0e;
  wire logic wr3 = REG_WR_IN && REG_ADDR_IN == 8'h0e;
  property p_rst; disable iff (1'b0) RST_IN |=> REG_RDATA_OUT == 16'h0000; endproperty
  a_rst: assert property (p_rst) else $error("read data not cleared by reset");
  property p_hold; !REG_RD_IN |=> $stable(REG_RDATA_OUT); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  property p_unmap; REG_RD_IN && !(REG_ADDR_IN inside {8'h0d, 8'h0e}) |=> REG_RDATA_OUT == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_resv; rd3 |=> REG_RDATA_OUT[5:4] == 2'b00; endproperty
  a_resv: assert property (p_resv) else $error("reserved bits not zero");
  property p_inv; INVALID_ACCESS_IN ##1 rd3 |=> REG_RDATA_OUT[0]; endproperty
  a_inv: assert property (p_inv) else $error("invalid access not flagged");
  property p_crc; CRC_ERROR_IN ##1 rd3 |=> REG_RDATA_OUT[1]; endproperty
  a_crc: assert property (p_crc) else $error("crc error not flagged");
  property p_clr; wr3 && REG_WDATA_IN[0] && !INVALID_ACCESS_IN ##1 rd3 |=> !REG_RDATA_OUT[0]; endproperty
  a_clr: assert property (p_clr) else $error("write one did not clear");
  property p_keep; INVALID_ACCESS_IN ##1 (wr3 && !REG_WDATA_IN[0]) ##1 rd3 |=> REG_RDATA_OUT[0]; endproperty
  a_keep: assert property (p_keep) else $error("write zero cleared a flag");
  c_inv: cover property (INVALID_ACCESS_IN ##1 rd3);
  c_clr: cover property (wr3 ##1 rd3);
  c_unmap: cover property (REG_RD_IN && REG_ADDR_IN == 8'h0f);
endmodule // flag_checker
bind main_status_flag_bank flag_checker flag_checker_i (.MCLK_IN, .RST_IN, .REG_ADDR_IN, .REG_WR_IN, .REG_RD_IN,
  .REG_WDATA_IN, .REG_RDATA_OUT, .INVALID_ACCESS_IN, .CRC_ERROR_IN);
`default_nettype wire

// ===== verification/main_status_flag_bank_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module main_status_flag_bank_tb_top;
  logic MCLK_IN = 0, RST_IN = 1, inv = 0, crc = 0, clk_ok = 0;
  logic [1:0] wake = 0;
  logic [13:0] ev = 0;
  logic [8:0] reg_on = 0;
  logic [7:0] addr;
  logic wr, rd;
  logic [15:0] wdata, rdata, q;
  int num_errors = 0, comparisons = 0;
  host_model host_model_i (.MCLK_IN(MCLK_IN), .rdata_in(rdata), .addr_out(addr), .wr_out(wr), .rd_out(rd),
    .wdata_out(wdata));
  main_status_flag_bank main_status_flag_bank_i (.MCLK_IN(MCLK_IN), .RST_IN(RST_IN), .REG_ADDR_IN(addr),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .INVALID_ACCESS_IN(inv),
    .CRC_ERROR_IN(crc), .WAKE_INPUT_ONE_IN(wake[0]), .WAKE_INPUT_TWO_IN(wake[1]),
    .INPUT_CLOCK_IN_RANGE_IN(clk_ok), .STANDBY_TIMER_EVENT_IN(ev[8]), .BOOST_OVERVOLTAGE_EVENT_IN(ev[9]),
    .BOOST_UNDERVOLTAGE_EVENT_IN(ev[10]), .BOOST_SOURCE_UNDERVOLTAGE_EVENT_IN(ev[11]),
    .THERMAL_SELFTEST_FAIL_IN(ev[12]), .DIE_CENTRE_THERMAL_EVENT_IN(ev[13]),
    .OTHER_SUPPLY_EVENTS_IN(ev[7:0]), .REGULATOR_ON_IN(reg_on));
  task automatic end_sim;
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e);
    comparisons++;
    if (q !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, q);
    end
  endtask
  task automatic wrt(input logic [7:0] a, input logic [15:0] d);
    host_model_i.xfer(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] e, input string n);
    host_model_i.xfer(1'b0, a, 16'h0000, q);
    chk(n, e);
  endtask
  initial forever #25 MCLK_IN = ~MCLK_IN;
  initial begin
    #20000;
    num_errors++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge MCLK_IN);
    #1 RST_IN = 0;
    rdc(8'h0d, 16'h0000, "flags2");
    rdc(8'h0e, 16'h0000, "flags3");
    wake = 2'b01;
    clk_ok = 1;
    reg_on = 9'h1a5;
    ev = 14'h3f81;
    host_model_i.idle(4);
    ev = 0;
    host_model_i.idle(4);
    rdc(8'h0d, 16'hfe05, "events");
    rdc(8'h0e, 16'hd2c4, "live");
    wake = 2'b10;
    host_model_i.idle(4);
    rdc(8'h0e, 16'hd2c8, "wake2");
    wrt(8'h0d, 16'h0000);
    rdc(8'h0d, 16'hfe07, "zero write");
    wrt(8'h0d, 16'hffff);
    rdc(8'h0d, 16'h0000, "cleared");
    inv = 1;
    crc = 1;
    host_model_i.idle(1);
    inv = 0;
    crc = 0;
    rdc(8'h0e, 16'hd2cb, "link");
    inv = 1;
    host_model_i.idle(1);
    inv = 0;
    wrt(8'h0e, 16'hfffc);
    rdc(8'h0e, 16'hd2cb, "ro write");
    wrt(8'h0e, 16'hffff);
    rdc(8'h0e, 16'hd2c8, "link clr");
    rdc(8'h0f, 16'h0000, "unmapped");
    ev = 14'h2000;
    host_model_i.idle(4);
    wrt(8'h0d, 16'hffff);
    rdc(8'h0d, 16'h8000, "reset");
    ev = 0;
    clk_ok = 0;
    reg_on = 9'h05a;
    wake = 2'b00;
    host_model_i.idle(4);
    rdc(8'h0e, 16'h2d00, "out of range");
    host_model_i.idle(1);
    RST_IN = 1;
    host_model_i.idle(3);
    RST_IN = 0;
    rdc(8'h0d, 16'h0000, "mid reset");
    end_sim();
  end
endmodule // main_status_flag_bank_tb_top
`default_nettype wire
